// file: hdl/rxp_pins.sv
// Functional notes
// RL1: Reset after 64 clean low periods.
// RL2: Reset low forces ports to reset immediately.
// RL3: Reset wakes from idle and power-down.
// RL4: Internal reset drives pin low 12 periods; the code holds it low for 13.
// RL5: Fetch select low: external code from 0000h.
// RL6: Fetch select latched at reset, then frozen.
// RL7: Low address valid at strobe falling edge.
// RL8: Address strobe only for external moves.
// RL9: Low address and data share low lines.
// RL10: High address byte on high lines.
// RL11: Read strobe spans external read cycle.
// RL12: Write strobe spans external write cycle.
// RL13: Slave mode: read strobe is an input.
// RL14: Slave mode: write strobe is an input.
// RL15: Slave low data byte on low lines.
// RL16: Slave high byte only in 16-bit mode.
// RL17: Test entry pin high for normal operation.
// RL18: Synchronise reset and count consecutive lows.
`timescale 1ns/1ps
module rxp_pins
   import rxp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rst_pin_n_i,
   input wire logic int_rst_req_i,
   input wire logic fetch_sel_n_i,
   input wire logic test_entry_pin_i,
   input wire logic idle_req_i,
   input wire logic pdown_req_i,
   input wire logic slave_mode_i,
   input wire logic slave_wide_i,
   input wire logic [7:0] slave_lo_i,
   input wire logic [7:0] slave_hi_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic [7:0] ad_i,
   input wire logic [7:0] ahi_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   output logic core_rst_o,
   output logic rst_pin_n_o,
   output logic rst_pin_oe_n_o,
   output logic port_force_o,
   output logic ext_fetch_o,
   output logic [15:0] fetch_start_o,
   output logic test_mode_o,
   output logic [1:0] pwr_state_o,
   output logic [7:0] ad_o,
   output logic [7:0] ad_oe_n_o,
   output logic [7:0] ahi_o,
   output logic [7:0] ahi_oe_n_o,
   output logic ale_o,
   output logic rd_n_o,
   output logic rd_oe_n_o,
   output logic wr_n_o,
   output logic wr_oe_n_o,
   output logic mem_done_o,
   output logic [7:0] mem_rdata_o,
   output logic slave_rd_o,
   output logic slave_wr_o,
   output logic [15:0] slave_wdata_o
);
   import rxp_pkg::*;

   logic rst_hit;
   logic stretch_busy;
   logic in_reset;
   logic rd_s;
   logic wr_s;
   logic rd_d;
   logic wr_d;
   rxp_pwr_e pwr;
   rxp_bus_e bus;
   logic [2:0] bcnt;
   logic bus_we;
   logic [15:0] baddr;
   logic [7:0] bdata;

   function automatic logic [7:0] oe_n_byte(input logic drive);
      oe_n_byte = drive ? 8'h00 : 8'hff;
   endfunction

   // Phase decoding shared by the pin drivers and the read capture.
   function automatic logic addr_phase(input rxp_bus_e st);
      addr_phase = (st == RXP_BUS_ADDR) || (st == RXP_BUS_HOLD);
   endfunction

   function automatic logic rd_phase(input rxp_bus_e st, input logic we);
      rd_phase = (st == RXP_BUS_STROBE) && !we;
   endfunction

   function automatic logic wr_phase(input rxp_bus_e st, input logic we);
      wr_phase = (st == RXP_BUS_STROBE) && we;
   endfunction

   rxp_rst_filter u_filter (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .rst_pin_i(rst_pin_n_i),
      .rst_hit_o(rst_hit)
   );

   rxp_rst_stretch u_stretch (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(int_rst_req_i),
      .busy_o(stretch_busy)
   );

   assign in_reset = rst_hit || stretch_busy;

   // Reset pin is open drain, pulled low during an internal reset.
   always_ff @(posedge core_clk_i) begin
      rst_pin_n_o <= 1'b0;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rst_pin_oe_n_o <= 1'b1;
      end else begin
         rst_pin_oe_n_o <= !(int_rst_req_i || stretch_busy); // see RL4
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         core_rst_o <= 1'b1;
      end else begin
         core_rst_o <= in_reset; // see RL1
      end
   end

   // Port forcing follows the raw pin level without any filtering.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         port_force_o <= 1'b1;
      end else begin
         port_force_o <= !rst_pin_n_i || in_reset; // see RL2
      end
   end

   // Every kind of reset samples the strap pins; they freeze afterwards.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         ext_fetch_o <= !fetch_sel_n_i; // see RL6
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         fetch_start_o <= RXP_EXT_START_ADDR; // see RL5
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         test_mode_o <= !test_entry_pin_i; // see RL17
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pwr <= RXP_PWR_RUN;
      end else if (in_reset || !rst_pin_n_i) begin
         pwr <= RXP_PWR_RUN; // see RL3
      end else if (pdown_req_i) begin
         pwr <= RXP_PWR_DOWN;
      end else if (idle_req_i && pwr == RXP_PWR_RUN) begin
         pwr <= RXP_PWR_IDLE;
      end
   end
   assign pwr_state_o = pwr;

   // External memory cycle: address phase, strobe phase, done.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset || slave_mode_i) begin
         bus <= RXP_BUS_IDLE;
         bcnt <= 3'h0;
         bus_we <= 1'b0;
         baddr <= 16'h0000;
         bdata <= 8'h00;
      end else begin
         case (bus)
            RXP_BUS_IDLE: begin
               if (mem_req_i && pwr == RXP_PWR_RUN) begin
                  bus <= RXP_BUS_ADDR; // see RL8
                  bus_we <= mem_we_i;
                  baddr <= mem_addr_i;
                  bdata <= mem_wdata_i;
                  bcnt <= 3'(RXP_ALE_CYC - 1);
               end
            end
            RXP_BUS_ADDR: begin
               if (bcnt == 3'h0) begin
                  bus <= RXP_BUS_HOLD;
               end else begin
                  bcnt <= bcnt - 3'h1;
               end
            end
            RXP_BUS_HOLD: begin
               bus <= RXP_BUS_STROBE;
               bcnt <= 3'(RXP_STROBE_CYC - 1);
            end
            RXP_BUS_STROBE: begin
               if (bcnt == 3'h0) begin
                  bus <= RXP_BUS_DONE;
               end else begin
                  bcnt <= bcnt - 3'h1;
               end
            end
            RXP_BUS_DONE: begin
               bus <= RXP_BUS_IDLE;
            end
            default: begin
               bus <= RXP_BUS_IDLE;
            end
         endcase
      end
   end

   // Pin drive follows the cycle engine one clock later.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset || slave_mode_i) begin
         ale_o <= 1'b0;
      end else begin
         ale_o <= (bus == RXP_BUS_ADDR) && (bcnt != 3'h0); // see RL7
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         ad_o <= RXP_PORT_RESET_VAL;
         ad_oe_n_o <= 8'hff;
      end else if (slave_mode_i) begin
         ad_o <= slave_lo_i; // see RL15
         ad_oe_n_o <= oe_n_byte(!rd_n_i);
      end else if (addr_phase(bus)) begin
         ad_o <= baddr[7:0]; // see RL9
         ad_oe_n_o <= 8'h00;
      end else if (wr_phase(bus, bus_we)) begin
         ad_o <= bdata; // see RL9
         ad_oe_n_o <= 8'h00;
      end else begin
         ad_o <= RXP_PORT_RESET_VAL;
         ad_oe_n_o <= 8'hff;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         ahi_o <= RXP_PORT_RESET_VAL;
         ahi_oe_n_o <= 8'hff;
      end else if (slave_mode_i) begin
         ahi_o <= slave_hi_i; // see RL16
         ahi_oe_n_o <= oe_n_byte(!rd_n_i && slave_wide_i);
      end else begin
         ahi_o <= baddr[15:8]; // see RL10
         ahi_oe_n_o <= oe_n_byte(bus != RXP_BUS_IDLE);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset || slave_mode_i) begin
         rd_n_o <= 1'b1;
         rd_oe_n_o <= 1'b1; // see RL13
      end else begin
         rd_n_o <= !rd_phase(bus, bus_we); // see RL11
         rd_oe_n_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset || slave_mode_i) begin
         wr_n_o <= 1'b1;
         wr_oe_n_o <= 1'b1; // see RL14
      end else begin
         wr_n_o <= !wr_phase(bus, bus_we); // see RL12
         wr_oe_n_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         mem_done_o <= 1'b0;
      end else begin
         mem_done_o <= (bus == RXP_BUS_DONE);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         mem_rdata_o <= 8'h00;
      end else if (rd_phase(bus, bus_we) && bcnt == 3'h0) begin
         mem_rdata_o <= ad_i; // see RL11
      end
   end

   // Slave strobes are inputs; their rising edge ends a host cycle.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_s <= 1'b1;
         rd_d <= 1'b1;
      end else begin
         rd_s <= rd_n_i;
         rd_d <= rd_s;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_s <= 1'b1;
         wr_d <= 1'b1;
      end else begin
         wr_s <= wr_n_i;
         wr_d <= wr_s;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         slave_rd_o <= 1'b0;
      end else begin
         slave_rd_o <= slave_mode_i && rd_s && !rd_d; // see RL13
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         slave_wr_o <= 1'b0;
      end else begin
         slave_wr_o <= slave_mode_i && wr_s && !wr_d; // see RL14
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || in_reset) begin
         slave_wdata_o <= 16'h0000;
      end else if (slave_mode_i && !wr_n_i) begin
         slave_wdata_o[7:0] <= ad_i; // see RL15
         slave_wdata_o[15:8] <= slave_wide_i ? ahi_i : 8'h00; // see RL16
      end
   end
endmodule

// file: hdl/rxp_pkg.sv
package rxp_pkg;
   localparam int RXP_CLK_MHZ = 250;
   // Oscillator periods are clock cycles of core_clk_i.
   localparam int RXP_RST_FILTER_PERIODS = 64;
   localparam int RXP_RST_FILTER_CYC = RXP_RST_FILTER_PERIODS;
   localparam int RXP_RST_OUT_PERIODS = 12;
   localparam int RXP_RST_OUT_CYC = RXP_RST_OUT_PERIODS;
   localparam logic [15:0] RXP_EXT_START_ADDR = 16'h0000;
   localparam logic [7:0] RXP_PORT_RESET_VAL = 8'hff;
   localparam logic RXP_FETCH_RESET_VAL = 1'b0;
   localparam int RXP_ALE_CYC = 2;
   localparam int RXP_STROBE_CYC = 4;
   typedef enum logic [1:0] {
      RXP_PWR_RUN,
      RXP_PWR_IDLE,
      RXP_PWR_DOWN
   } rxp_pwr_e;
   typedef enum logic [2:0] {
      RXP_BUS_IDLE,
      RXP_BUS_ADDR,
      RXP_BUS_HOLD,
      RXP_BUS_STROBE,
      RXP_BUS_DONE
   } rxp_bus_e;
endpackage

// file: hdl/rxp_rst_filter.sv
`timescale 1ns/1ps
module rxp_rst_filter
   import rxp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rst_pin_i,
   output logic rst_hit_o
);
   logic sync_a;
   logic sync_b;
   logic [6:0] low_cnt;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= rst_pin_i;
         sync_b <= sync_a;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i || sync_b) begin
         low_cnt <= 7'h00; // see RL18
      end else if (low_cnt < 7'(RXP_RST_FILTER_CYC)) begin
         low_cnt <= low_cnt + 7'h01; // see RL18
      end
   end
   assign rst_hit_o = (low_cnt == 7'(RXP_RST_FILTER_CYC)); // see RL1
endmodule

// file: hdl/rxp_rst_stretch.sv
`timescale 1ns/1ps
module rxp_rst_stretch
   import rxp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   output logic busy_o
);
   logic [3:0] cnt;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
      end else if (start_i) begin
         cnt <= 4'(RXP_RST_OUT_CYC); // see RL4
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
   assign busy_o = (cnt != 4'h0);
endmodule

// file: verification/rxp_pins_checker.sv
`timescale 1ns/1ps
module rxp_pins_checker (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rst_pin_n_i,
   input wire logic int_rst_req_i,
   input wire logic mem_req_i,
   input wire logic slave_mode_i,
   input wire logic core_rst_o,
   input wire logic rst_pin_oe_n_o,
   input wire logic port_force_o,
   input wire logic ext_fetch_o,
   input wire logic [1:0] pwr_state_o,
   input wire logic [7:0] ad_o,
   input wire logic [7:0] ad_oe_n_o,
   input wire logic [7:0] ahi_oe_n_o,
   input wire logic ale_o,
   input wire logic rd_n_o,
   input wire logic rd_oe_n_o,
   input wire logic wr_n_o,
   input wire logic wr_oe_n_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   logic [6:0] lo_cnt;
   // Counts consecutive low samples of the reset pin.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || rst_pin_n_i) lo_cnt <= 7'h00;
      else if (lo_cnt != 7'h7f) lo_cnt <= lo_cnt + 7'h01;
   end
   sequence s_pin8;
      (!rst_pin_oe_n_o)[*8];
   endsequence
   sequence s_rd4;
      (!rd_n_o && !rd_oe_n_o)[*4];
   endsequence
   sequence s_wr4;
      (!wr_n_o && !wr_oe_n_o && ad_oe_n_o == 8'h00)[*4];
   endsequence
   AST_RST_LONG: assert property (lo_cnt >= 7'd70 |-> core_rst_o)
      else $error("Long reset low gave no reset.");
   AST_PORT_FORCE: assert property (!rst_pin_n_i |=> port_force_o)
      else $error("Ports not forced.");
   AST_WAKE: assert property (!rst_pin_n_i |-> ##[1:3] pwr_state_o == 2'd0)
      else $error("No wake on reset.");
   AST_INT_RST: assert property (int_rst_req_i |=> s_pin8 ##1 (!rst_pin_oe_n_o)[*4])
      else $error("Reset pin pulse too short.");
   AST_FETCH_HOLD: assert property (!core_rst_o && !$past(core_rst_o)
      && !$past(core_rst_o, 2) |-> $stable(ext_fetch_o))
      else $error("Fetch select changed outside reset.");
   AST_ALE_CAUSE: assert property ($rose(ale_o) |-> !slave_mode_i
      && ($past(mem_req_i) || $past(mem_req_i, 2)))
      else $error("Address strobe without access.");
   AST_ADDR_LATCH: assert property ($fell(ale_o) |-> ad_o == $past(ad_o)
      && $past(ad_oe_n_o) == 8'h00 && ahi_oe_n_o == 8'h00)
      else $error("Address not held at strobe fall.");
   AST_RD_SPAN: assert property ($fell(rd_n_o) && !rd_oe_n_o |-> s_rd4 ##1 rd_n_o)
      else $error("Read strobe span wrong.");
   AST_WR_SPAN: assert property ($fell(wr_n_o) && !wr_oe_n_o |-> s_wr4 ##1 wr_n_o)
      else $error("Write strobe span wrong.");
   AST_SLAVE_IN: assert property (slave_mode_i && $past(slave_mode_i, 2)
      |-> rd_oe_n_o && wr_oe_n_o)
      else $error("Slave strobes driven.");
endmodule
bind rxp_pins rxp_pins_checker u_chk (.*);

// file: verification/rxp_mem_model.sv
`timescale 1ns/1ps
module rxp_mem_model (
   input wire logic core_clk_i,
   input wire logic ale_i,
   input wire logic [7:0] ad_i,
   input wire logic [7:0] ahi_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   output logic [7:0] ad_o
);
   logic [7:0] mem [0:255];
   logic [15:0] addr = 16'h0000;
   logic [7:0] last = 8'h00;
   logic ale_q = 1'b0;
   wire [7:0] idx = addr[7:0] ^ addr[15:8];
   always @(posedge core_clk_i) begin
      ale_q <= ale_i;
      if (ale_q && !ale_i) addr <= {ahi_i, ad_i};
      if (!wr_n_i) mem[idx] <= ad_i;
      if (!rd_n_i) last <= ad_o;
   end
   // Released bus shows the inverse of its last value.
   assign ad_o = rd_n_i ? ~last : mem[idx];
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rxp_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i, rst_pin_n_i, int_rst_req_i, fetch_sel_n_i, test_entry_pin_i;
   logic idle_req_i, pdown_req_i, slave_mode_i, slave_wide_i, mem_req_i;
   logic mem_we_i, rd_n_i, wr_n_i, core_rst_o, rst_pin_n_o, rst_pin_oe_n_o;
   logic port_force_o, ext_fetch_o, test_mode_o, ale_o, rd_n_o, rd_oe_n_o;
   logic wr_n_o, wr_oe_n_o, mem_done_o, slave_rd_o, slave_wr_o;
   logic host_rd, host_wr;
   logic [7:0] slave_lo_i, slave_hi_i, mem_wdata_i, ad_i, ahi_i, ad_o;
   logic [7:0] ad_oe_n_o, ahi_o, ahi_oe_n_o, mem_rdata_o, host_ad, host_hi;
   logic [7:0] mem_ad;
   logic [15:0] mem_addr_i, fetch_start_o, slave_wdata_o, d;
   logic [1:0] pwr_state_o;
   logic [16:0] exp_q[$];
   logic [16:0] e;
   int num_errors = 0;
   int n_compared = 0;
   int seed = 32'h6c6f;
   int i, k;
   always #2 core_clk_i = ~core_clk_i;
   assign ad_i = (~ad_oe_n_o & ad_o)
      | (ad_oe_n_o & (slave_mode_i ? host_ad : mem_ad));
   assign ahi_i = (~ahi_oe_n_o & ahi_o) | (ahi_oe_n_o & host_hi);
   assign rd_n_i = rd_oe_n_o ? host_rd : rd_n_o;
   assign wr_n_i = wr_oe_n_o ? host_wr : wr_n_o;
   rxp_pins uut (.*);
   rxp_mem_model u_mem (.core_clk_i(core_clk_i), .ale_i(ale_o), .ad_i(ad_o),
      .ahi_i(ahi_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_o(mem_ad));
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic final_report;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic mem_op(input logic we, input logic [15:0] a);
      int n;
      exp_q.push_back(we ? 17'h10000 : {9'h000, d[7:0]});
      mem_req_i = 1'b1;
      mem_we_i = we;
      mem_addr_i = a;
      mem_wdata_i = d[7:0];
      tick(1);
      mem_req_i = 1'b0;
      for (n = 0; n < 30 && mem_done_o !== 1'b1; n++) tick(1);
      if (n == 30) begin
         num_errors++;
         final_report();
      end
      tick(1);
   endtask
   task automatic slv(input logic w);
      slave_wide_i = w;
      {host_hi, host_ad} = d;
      {slave_hi_i, slave_lo_i} = ~d;
      exp_q.push_back({w, w ? d[15:8] : 8'h00, d[7:0]});
      host_wr = 1'b0;
      tick(3);
      host_wr = 1'b1;
      {host_hi, host_ad} = ~d;
      tick(6);
      host_rd = 1'b0;
      tick(3);
      chk({ad_oe_n_o, ad_o}, {8'h00, ~d[7:0]});
      chk({ahi_oe_n_o, w ? ahi_o : 8'h00}, w ? {8'h00, ~d[15:8]} : 16'hff00);
      chk({14'h0, rd_oe_n_o, wr_oe_n_o}, 16'h0003);
      host_rd = 1'b1;
      tick(2);
      chk({15'h0, slave_rd_o}, 16'h0001);
      tick(1);
   endtask
   // Pops the oldest note whenever a transfer result appears.
   always @(negedge core_clk_i) begin
      if (mem_done_o === 1'b1 || slave_wr_o === 1'b1) begin
         if (exp_q.size() == 0) chk(16'hdead, 16'h0000);
         else begin
            e = exp_q.pop_front();
            if (slave_wr_o === 1'b1) chk(slave_wdata_o, e[15:0]);
            else if (!e[16]) chk({8'h00, mem_rdata_o}, e[15:0]);
         end
      end
   end
   initial begin
      {rst_i, rst_pin_n_i, fetch_sel_n_i, test_entry_pin_i} = 4'b1101;
      {int_rst_req_i, idle_req_i, pdown_req_i, slave_mode_i} = 4'h0;
      {slave_wide_i, mem_req_i, mem_we_i, host_rd, host_wr} = 5'b00011;
      {slave_lo_i, slave_hi_i, host_ad, host_hi} = 32'h0;
      {mem_addr_i, mem_wdata_i, d} = 40'h0;
      tick(10);
      rst_i = 1'b0;
      tick(3);
      chk({14'h0, ext_fetch_o, test_mode_o}, 16'h0002);
      chk(fetch_start_o, 16'h0000);
      fetch_sel_n_i = 1'b1;
      tick(5);
      chk({15'h0, ext_fetch_o}, 16'h0001);
      rst_pin_n_i = 1'b0;
      tick(2);
      chk({15'h0, port_force_o}, 16'h0001);
      tick(70);
      chk({15'h0, core_rst_o}, 16'h0001);
      rst_pin_n_i = 1'b1;
      tick(20);
      chk({13'h0, core_rst_o, port_force_o, ext_fetch_o}, 16'h0);
      for (i = 0; i < 2; i++) begin
         rst_pin_n_i = 1'b0;
         tick(50);
         rst_pin_n_i = 1'b1;
         tick(1);
      end
      chk({15'h0, core_rst_o}, 16'h0000);
      tick(5);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         d = 16'($random(seed));
         k = $random(seed);
         mem_op(1'b1, k[15:0]);
         mem_op(1'b0, k[15:0]);
      end
      $display("test bus done");
      slave_mode_i = 1'b1;
      tick(3);
      for (i = 0; i < 4; i++) begin
         d = 16'($random(seed));
         slv(i[0]);
      end
      mem_req_i = 1'b1;
      tick(1);
      mem_req_i = 1'b0;
      tick(15);
      slave_mode_i = 1'b0;
      tick(3);
      $display("test slave done");
      int_rst_req_i = 1'b1;
      tick(1);
      int_rst_req_i = 1'b0;
      for (k = 0; k < 40 && rst_pin_oe_n_o === 1'b0; k++) tick(1);
      if (k == 40) begin
         num_errors++;
         final_report();
      end
      chk({15'h0, k >= 12 && k < 40}, 16'h0001);
      chk({15'h0, rst_pin_n_o}, 16'h0000);
      tick(5);
      $display("test internal reset done");
      for (i = 0; i < 2; i++) begin
         {idle_req_i, pdown_req_i} = i[0] ? 2'b01 : 2'b10;
         tick(1);
         {idle_req_i, pdown_req_i} = 2'b00;
         tick(3);
         chk({14'h0, pwr_state_o}, i[0] ? 16'h2 : 16'h1);
         rst_pin_n_i = 1'b0;
         tick(3);
         rst_pin_n_i = 1'b1;
         tick(5);
         chk({14'h0, pwr_state_o}, 16'h0000);
      end
      $display("test wake done");
      final_report();
   end
endmodule
